// File: fdp_map.svh
// constants of the discovery parameter store: offsets and field values
// assumes inclusion by bare name from a package or module
`ifndef FDP_MAP_SVH
`define FDP_MAP_SVH
`define FDP_BASE_ADDR 8'h48
`define FDP_LAST_ADDR 8'h7B
`define FDP_WORD_COUNT 4'hD
`define FDP_RFU_BYTE 8'hFF
`define FDP_QPI_MODE_CYC 3'h2
`define FDP_QPI_DUMMY_CYC 5'h04
`define FDP_QPI_READ_OP 8'hEB
`define FDP_ER1_SIZE 8'h0C
`define FDP_ER1_OP 8'h20
`define FDP_ER2_SIZE 8'h0F
`define FDP_ER2_OP 8'h52
`define FDP_ER3_SIZE 8'h10
`define FDP_ER3_OP 8'hD8
`define FDP_ER4_SIZE 8'h00
`define FDP_ER4_OP 8'hFF
`define FDP_ER4_UNIT 2'h3
`define FDP_ER4_CNT 5'h1F
`define FDP_ER3_UNIT 2'h1
`define FDP_ER3_CNT 5'h09
`define FDP_ER2_UNIT 2'h1
`define FDP_ER2_CNT 5'h00
`define FDP_ER1_UNIT 2'h1
`define FDP_ER1_CNT 5'h02
`define FDP_ER_MAX_MULT 4'h1
`define FDP_CE_RSV 1'h1
`define FDP_CE_UNIT 2'h2
`define FDP_CE_CNT 5'h07
`define FDP_BN_UNIT 1'h0
`define FDP_BN_CNT 4'h2
`define FDP_BF_UNIT 1'h1
`define FDP_BF_CNT 4'h1
`define FDP_PP_UNIT 1'h1
`define FDP_PP_CNT 5'h07
`define FDP_PAGE_EXP 4'h8
`define FDP_PP_MAX_MULT 4'h2
`define FDP_SR_UNSUP 1'h0
`define FDP_ES_UNIT 2'h1
`define FDP_ES_CNT 5'h13
`define FDP_ES_IVL 4'h1
`define FDP_PS_UNIT 2'h1
`define FDP_PS_CNT 5'h13
`define FDP_PS_IVL 4'h1
`define FDP_D12_RFU 1'h1
`define FDP_ES_PROHIB 4'hE
`define FDP_PS_PROHIB 4'hC
`define FDP_SUSPEND_OP 8'h75
`define FDP_RESUME_OP 8'h7A
`define FDP_DPD_UNSUP 1'h0
`define FDP_DPD_ENTER_OP 8'hB9
`define FDP_DPD_EXIT_OP 8'hAB
`define FDP_DPD_UNIT 2'h1
`define FDP_DPD_CNT 5'h02
`define FDP_D14_RFU_HI 4'hF
`define FDP_BUSY_POLL 2'h1
`define FDP_D14_RFU_LO 2'h3
`define FDP_HOLD_WP_DIS 1'h1
`define FDP_QER 3'h5
`define FDP_M044_ENTRY 4'hD
`define FDP_M044_EXIT 6'h3D
`define FDP_M044_SUPP 1'h1
`define FDP_QPI_EN_SEQ 5'h01
`define FDP_QPI_DIS_SEQ 4'h9
`define FDP_D16_WORD 32'h80C030E8
`define FDP_VCC_MAX 16'h3600
`define FDP_VCC_MIN 16'h2300
`define FDP_FEAT_FLAGS 24'h77F99F
`define FDP_WRAP_LEN 8'h64
`define FDP_LOCK_WORD 16'hE9B1
`endif

// File: fdp_pkg.sv
// types shared by the discovery store and its byte picker
// assumes the map header sits in the include path
package fdp_pkg;
  typedef logic [7:0] fdp_byte_t;
  typedef logic [31:0] fdp_dword_t;
  typedef logic [3:0] fdp_idx_t;
  typedef enum logic {FDP_EMPTY, FDP_FULL} fdp_state_t;
endpackage

// File: fdp_rom_if.sv
// link between the store and its byte picker
// assumes both ends are combinational on these signals
interface fdp_rom_if;
  import fdp_pkg::*;
  fdp_byte_t addr;
  fdp_dword_t word;
  fdp_idx_t idx;
  logic mapped;
  fdp_byte_t byte_out;
  modport store (output addr, word, input idx, mapped, byte_out);
  modport pick (input addr, word, output idx, mapped, byte_out);
endinterface

// File: fdp_byte_pick.sv
// address decode and byte lane select for the discovery store
// assumes the store returns the word of idx in the same cycle
`include "fdp_map.svh"
module fdp_byte_pick
  import fdp_pkg::*;
(
  fdp_rom_if.pick rom
);
  // ****************************************
  // decode
  // ****************************************
  fdp_byte_t rel;

  always_comb begin
    rel = rom.addr - `FDP_BASE_ADDR;
    rom.mapped = (rom.addr >= `FDP_BASE_ADDR) &&
                 (rom.addr <= `FDP_LAST_ADDR);
    rom.idx = rel[5:2];
  end

  // ****************************************
  // byte lane, lowest address in bits 7:0
  // ****************************************
  always_comb begin
    if (!rom.mapped) begin
      rom.byte_out = `FDP_RFU_BYTE;
    end else begin
      unique case (rel[1:0])
        2'h0: rom.byte_out = rom.word[7:0];
        2'h1: rom.byte_out = rom.word[15:8];
        2'h2: rom.byte_out = rom.word[23:16];
        2'h3: rom.byte_out = rom.word[31:24];
      endcase
    end
  end
endmodule

// File: fdp_param_rom.sv
// read-only discovery parameter store, bytes 48h to 7Bh
// assumes a command decoder in front that issues byte reads
`include "fdp_map.svh"
module fdp_param_rom
  import fdp_pkg::*;
#(
  parameter logic [7:0] LOCK_HI = 8'hE9
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // byte read requests
  input wire logic rd_valid,
  input wire logic rd_first,
  input wire logic [7:0] rd_addr,
  output logic rd_ready,
  // byte read answers
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_data,
  output logic rsp_mapped,
  // decoded timing view
  output logic [15:0] er1_typ_ms,
  output logic [15:0] er2_typ_ms,
  output logic [15:0] er3_typ_ms,
  output logic [4:0] er_max_factor,
  output logic [11:0] page_bytes,
  output logic [15:0] pp_typ_us,
  output logic [15:0] dpd_exit_ns
);

  // ****************************************
  // word contents
  // ****************************************
  // every word but 9 is built from its fields so each value shows its meaning

  function automatic fdp_dword_t fdp_word(input fdp_idx_t i);
    fdp_dword_t w;
    w = {4{`FDP_RFU_BYTE}};
    unique case (i)
      4'h0: w = {`FDP_QPI_READ_OP, `FDP_QPI_MODE_CYC,
                 `FDP_QPI_DUMMY_CYC, `FDP_RFU_BYTE,
                 `FDP_RFU_BYTE};
      4'h1: w = {`FDP_ER2_OP, `FDP_ER2_SIZE,
                 `FDP_ER1_OP, `FDP_ER1_SIZE};
      4'h2: w = {`FDP_ER4_OP, `FDP_ER4_SIZE,
                 `FDP_ER3_OP, `FDP_ER3_SIZE};
      4'h3: w = {`FDP_ER4_UNIT, `FDP_ER4_CNT,
                 `FDP_ER3_UNIT, `FDP_ER3_CNT,
                 `FDP_ER2_UNIT, `FDP_ER2_CNT,
                 `FDP_ER1_UNIT, `FDP_ER1_CNT,
                 `FDP_ER_MAX_MULT};
      4'h4: w = {`FDP_CE_RSV, `FDP_CE_UNIT, `FDP_CE_CNT,
                 `FDP_BN_UNIT, `FDP_BN_CNT,
                 `FDP_BF_UNIT, `FDP_BF_CNT,
                 `FDP_PP_UNIT, `FDP_PP_CNT,
                 `FDP_PAGE_EXP,
                 `FDP_PP_MAX_MULT};
      4'h5: w = {`FDP_SR_UNSUP, `FDP_ES_UNIT, `FDP_ES_CNT,
                 `FDP_ES_IVL, `FDP_PS_UNIT, `FDP_PS_CNT,
                 `FDP_PS_IVL, `FDP_D12_RFU,
                 `FDP_ES_PROHIB, `FDP_PS_PROHIB};
      4'h6: w = {`FDP_SUSPEND_OP, `FDP_RESUME_OP,
                 `FDP_SUSPEND_OP, `FDP_RESUME_OP};
      4'h7: w = {`FDP_DPD_UNSUP, `FDP_DPD_ENTER_OP,
                 `FDP_DPD_EXIT_OP, `FDP_DPD_UNIT,
                 `FDP_DPD_CNT,
                 `FDP_D14_RFU_HI, `FDP_BUSY_POLL,
                 `FDP_D14_RFU_LO};
      4'h8: w = {`FDP_RFU_BYTE, `FDP_HOLD_WP_DIS,
                 `FDP_QER,
                 `FDP_M044_ENTRY,
                 `FDP_M044_EXIT,
                 `FDP_M044_SUPP,
                 `FDP_QPI_EN_SEQ, `FDP_QPI_DIS_SEQ};
      4'h9: w = `FDP_D16_WORD;
      4'hA: w = {`FDP_VCC_MIN, `FDP_VCC_MAX};
      4'hB: w = {`FDP_WRAP_LEN, `FDP_FEAT_FLAGS};
      4'hC: w = {`FDP_RFU_BYTE, `FDP_RFU_BYTE, LOCK_HI,
                 8'(`FDP_LOCK_WORD)};
      default: w = {4{`FDP_RFU_BYTE}};
    endcase
    return w;
  endfunction

  // ****************************************
  // time decode helpers
  // ****************************************
  // erase units are 1, 16, 128 ms or 1 s; the widest result is 32 s

  function automatic logic [15:0] fdp_erase_ms(input logic [1:0] u,
                                               input logic [4:0] c);
    logic [15:0] unit;
    logic [15:0] n;
    unit = 16'h0001;
    n = {11'h000, c} + 16'h0001;
    unique case (u)
      2'h0: unit = 16'h0001;
      2'h1: unit = 16'h0010;
      2'h2: unit = 16'h0080;
      2'h3: unit = 16'h03E8;
    endcase
    return 16'(n * unit);
  endfunction

  // suspend and power-down latency units are 128 ns, 1, 8 or 64 us
  function automatic logic [15:0] fdp_lat_ns(input logic [1:0] u,
                                             input logic [4:0] c);
    logic [15:0] unit;
    logic [15:0] n;
    unit = 16'h0080;
    n = {11'h000, c} + 16'h0001;
    unique case (u)
      2'h0: unit = 16'h0080;
      2'h1: unit = 16'h03E8;
      2'h2: unit = 16'h1F40;
      2'h3: unit = 16'hFA00;
    endcase
    return 16'(n * unit);
  endfunction

  // ****************************************
  // byte picker
  // ****************************************
  fdp_rom_if rom ();

  fdp_byte_pick u_pick (
    .rom (rom.pick)
  );

  // ****************************************
  // read handshake
  // ****************************************
  // one answer slot only; a new byte is taken when the slot drains,
  // so a stalled reader throttles requests without losing bytes

  fdp_state_t state;
  logic [7:0] last_addr;
  logic take;

  assign rd_ready = (state == FDP_EMPTY) || rsp_ready;
  assign take = rd_valid && rd_ready;
  assign rsp_valid = (state == FDP_FULL);

  // burst reads step one byte at a time from the first address
  always_comb begin
    rom.addr = rd_first ? rd_addr : 8'(last_addr + 8'h01);
    rom.word = fdp_word(rom.idx);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= FDP_EMPTY;
    end else if (take) begin
      state <= FDP_FULL;
    end else if (rsp_ready) begin
      state <= FDP_EMPTY;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_addr <= 8'hFF;
    end else if (take) begin
      last_addr <= rom.addr;
    end
  end

  // ****************************************
  // answer data
  // ****************************************
  // bytes outside the window answer FFh and drop the mapped flag

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_data <= 8'hFF;
      rsp_mapped <= 1'b0;
    end else if (take) begin
      rsp_data <= rom.byte_out;
      rsp_mapped <= rom.mapped;
    end
  end

  // ****************************************
  // decoded timing view
  // ****************************************
  // read straight from the stored fields so a field slip shows here too

  fdp_dword_t w_erase;
  fdp_dword_t w_prog;
  fdp_dword_t w_pdown;

  always_comb begin
    w_erase = fdp_word(4'h3);
    w_prog = fdp_word(4'h4);
    w_pdown = fdp_word(4'h7);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      er1_typ_ms <= 16'h0000;
      er2_typ_ms <= 16'h0000;
      er3_typ_ms <= 16'h0000;
      er_max_factor <= 5'h00;
    end else begin
      er1_typ_ms <= fdp_erase_ms(w_erase[10:9], w_erase[8:4]);
      er2_typ_ms <= fdp_erase_ms(w_erase[17:16], w_erase[15:11]);
      er3_typ_ms <= fdp_erase_ms(w_erase[24:23], w_erase[22:18]);
      er_max_factor <= 5'({1'b0, w_erase[3:0]} + 5'h01) << 1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_bytes <= 12'h000;
      pp_typ_us <= 16'h0000;
    end else begin
      page_bytes <= 12'h001 << w_prog[7:4];
      pp_typ_us <= 16'(({11'h000, w_prog[12:8]} + 16'h0001) *
                       (w_prog[13] ? 16'h0040 : 16'h0008));
    end
  end

  // exit delay kept in ns because the smallest unit is 128 ns
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dpd_exit_ns <= 16'h0000;
    end else begin
      dpd_exit_ns <= fdp_lat_ns(w_pdown[14:13], w_pdown[12:8]);
    end
  end

endmodule

// File: fdp_param_rom_assertions.sv
// port checker for the discovery parameter store
// assumes it is bound into every fdp_param_rom instance
module fdp_param_rom_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // byte reads
  input wire logic rd_valid,
  input wire logic rd_first,
  input wire logic [7:0] rd_addr,
  input wire logic rd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [7:0] rsp_data,
  // decoded view
  input wire logic [15:0] er1_typ_ms,
  input wire logic [4:0] er_max_factor,
  input wire logic [11:0] page_bytes,
  input wire logic [15:0] pp_typ_us,
  input wire logic [15:0] dpd_exit_ns
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // track the burst address so bytes taken mid-burst are checked too
  logic [7:0] chk_last;
  logic [7:0] eff_addr;
  assign eff_addr = rd_first ? rd_addr : 8'(chk_last + 8'h01);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chk_last <= 8'hFF;
    end else if (rd_valid && rd_ready) begin
      chk_last <= eff_addr;
    end
  end
  sequence s_take(a);
    rd_valid && rd_ready && eff_addr == a;
  endsequence
  property p_byte(a, d);
    s_take(a) |=> rsp_valid && rsp_data == d;
  endproperty
  // decoded view settles on the first edge after release, so skip that one
  property p_settled(sig, val);
    $past(reset_n) |-> sig == val;
  endproperty
  a_qpi_read_byte: assert property (p_byte(8'h4A, 8'h44))
    else $error("byte 4Ah wrong");
  a_erase1_size: assert property (p_byte(8'h4C, 8'h0C))
    else $error("byte 4Ch wrong");
  a_erase2_op: assert property (p_byte(8'h4F, 8'h52))
    else $error("byte 4Fh wrong");
  a_erase3_op: assert property (p_byte(8'h51, 8'hD8))
    else $error("byte 51h wrong");
  a_erase4_op: assert property (p_byte(8'h53, 8'hFF))
    else $error("byte 53h wrong");
  a_erase_time_top: assert property (p_byte(8'h57, 8'hFE))
    else $error("byte 57h wrong");
  a_chip_erase_byte: assert property (p_byte(8'h5B, 8'hC7))
    else $error("byte 5Bh wrong");
  a_wrap_len_byte: assert property (p_byte(8'h77, 8'h64))
    else $error("byte 77h wrong");
  a_er1_time: assert property (p_settled(er1_typ_ms, 16'h0030))
    else $error("erase one time wrong");
  a_max_factor: assert property (p_settled(er_max_factor, 5'h04))
    else $error("erase factor wrong");
  a_page_timing: assert property (
    $past(reset_n) |-> page_bytes == 12'h100 && pp_typ_us == 16'h0200)
    else $error("page timing wrong");
  a_dpd_delay: assert property (p_settled(dpd_exit_ns, 16'h0BB8))
    else $error("power-down delay wrong");
  a_answer_holds: assert property (rsp_valid && !rsp_ready |->
    !rd_ready ##1 rsp_valid && $stable(rsp_data))
    else $error("answer dropped while stalled");
  c_stall: cover property (rsp_valid && !rsp_ready);
  c_burst: cover property (rd_valid && rd_ready && !rd_first);
  c_qpi: cover property (s_take(8'h4A));
endmodule

bind fdp_param_rom fdp_param_rom_assertions u_fdp_param_rom_assertions (
  .clk, .reset_n, .rd_valid, .rd_first, .rd_addr, .rd_ready, .rsp_valid,
  .rsp_ready, .rsp_data, .er1_typ_ms, .er_max_factor, .page_bytes,
  .pp_typ_us, .dpd_exit_ns);

// File: fdp_host_model.sv
// host side reader of the discovery store
// assumes read is called just after a rising edge, reset released
module fdp_host_model (
  // clock
  input wire logic clk,
  // requests
  output logic rd_valid,
  output logic rd_first,
  output logic [7:0] rd_addr,
  input wire logic rd_ready,
  // answers
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_mapped
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [64];
  logic okm [64];
  int short_reads = 0;
  initial begin
    rd_valid = 1'b0;
    rd_first = 1'b0;
    rd_addr = 8'h00;
    rsp_ready = 1'b0;
  end
  // slow mode drains one cycle in three, so answers must wait
  task automatic read(input logic [7:0] a, input int n, input bit slow);
    int i;
    int k;
    int c;
    i = 0;
    k = 0;
    c = 0;
    while (k < n && c < 300) begin
      rd_valid = (i < n);
      rd_first = (i == 0);
      rd_addr = rd_valid ? a : ~a;
      rsp_ready = !slow || (c % 3 == 2);
      @(negedge clk);
      if (rsp_valid && rsp_ready) begin
        got[k] = rsp_data;
        okm[k] = rsp_mapped;
        k++;
      end
      if (rd_valid && rd_ready) i++;
      @(posedge clk);
      #1;
      c++;
    end
    rd_valid = 1'b0;
    rsp_ready = 1'b0;
    rd_addr = ~a;
    if (k < n) short_reads++;
    // one idle edge so a following call never re-raises in this step
    @(posedge clk);
    #1;
  endtask
endmodule

// File: tb.sv
// self-checking bench for the discovery parameter store
// assumes the host model and the bound checker are compiled alongside
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd_valid, rd_first, rd_ready, rsp_valid, rsp_ready, rsp_mapped;
  logic [7:0] rd_addr, rsp_data;
  logic [15:0] er1_typ_ms, er2_typ_ms, er3_typ_ms, pp_typ_us, dpd_exit_ns;
  logic [4:0] er_max_factor;
  logic [11:0] page_bytes;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam logic [415:0] exp_map = {
    128'hFFFF44EB_0C200F52_10D800FF_2102A5FE,
    128'h826714C7_EC631633_7A757A75_F7A2D55C,
    128'h19F6DDFF_E830C080_00360023_9FF97764,
    32'hB1E9FFFF};
  always #2.5 clk = ~clk;
  fdp_param_rom u_fdp_param_rom (.clk, .reset_n, .rd_valid, .rd_first,
    .rd_addr, .rd_ready, .rsp_valid, .rsp_ready, .rsp_data, .rsp_mapped,
    .er1_typ_ms, .er2_typ_ms, .er3_typ_ms, .er_max_factor, .page_bytes,
    .pp_typ_us, .dpd_exit_ns);
  fdp_host_model u_fdp_host_model (.clk, .rd_valid, .rd_first, .rd_addr,
    .rd_ready, .rsp_valid, .rsp_ready, .rsp_data, .rsp_mapped);
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    bad_count += u_fdp_host_model.short_reads;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // got[] is aligned to 48h only after the full sweep
  task automatic cmp_rng(input int a, input int n);
    for (int j = a - 72; j < a - 72 + n; j++) begin
      chk("map byte", u_fdp_host_model.got[j], exp_map[415 - 8 * j -: 8]);
      chk("mapped flag", u_fdp_host_model.okm[j], 1'b1);
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_map();
    u_fdp_host_model.read(8'h48, 52, 1'b0);
    cmp_rng(8'h48, 2);
    cmp_rng(8'h4A, 2);
    cmp_rng(8'h4C, 2);
    cmp_rng(8'h4E, 2);
    cmp_rng(8'h50, 2);
    cmp_rng(8'h52, 2);
    cmp_rng(8'h54, 4);
    cmp_rng(8'h58, 3);
    cmp_rng(8'h5B, 1);
    cmp_rng(8'h5C, 4);
    cmp_rng(8'h60, 4);
    cmp_rng(8'h64, 4);
    cmp_rng(8'h68, 4);
    cmp_rng(8'h6C, 11);
    cmp_rng(8'h77, 1);
    cmp_rng(8'h78, 4);
  endtask
  task automatic t_stall();
    u_fdp_host_model.read(8'h54, 8, 1'b1);
    for (int j = 0; j < 8; j++)
      chk("stalled byte", u_fdp_host_model.got[j],
        exp_map[415 - 8 * (12 + j) -: 8]);
  endtask
  task automatic t_edge();
    u_fdp_host_model.read(8'h7B, 2, 1'b0);
    chk("mapped 7Bh", u_fdp_host_model.okm[0], 1'b1);
    chk("data 7Bh", u_fdp_host_model.got[0], 8'hFF);
    chk("mapped 7Ch", u_fdp_host_model.okm[1], 1'b0);
    chk("data 7Ch", u_fdp_host_model.got[1], 8'hFF);
    u_fdp_host_model.read(8'h47, 2, 1'b0);
    chk("mapped 47h", u_fdp_host_model.okm[0], 1'b0);
    chk("data 47h", u_fdp_host_model.got[0], 8'hFF);
    chk("mapped 48h", u_fdp_host_model.okm[1], 1'b1);
  endtask
  task automatic t_decoded();
    chk("erase one ms", er1_typ_ms, 16'h0030);
    chk("erase two ms", er2_typ_ms, 16'h0010);
    chk("erase three ms", er3_typ_ms, 16'h00A0);
    chk("max factor", er_max_factor, 5'h04);
    chk("page bytes", page_bytes, 12'h100);
    chk("program us", pp_typ_us, 16'h0200);
    chk("wake ns", dpd_exit_ns, 16'h0BB8);
  endtask
  task automatic t_reset();
    reset_n = 1'b0;
    #1;
    chk("valid in reset", rsp_valid, 1'b0);
    chk("ready in reset", rd_ready, 1'b1);
    chk("data in reset", rsp_data, 8'hFF);
    chk("page in reset", page_bytes, 12'h000);
    @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    u_fdp_host_model.read(8'h4A, 1, 1'b0);
    chk("byte after reset", u_fdp_host_model.got[0], 8'h44);
    chk("page after reset", page_bytes, 12'h100);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    @(posedge clk);
    #1;
    t_map();
    t_stall();
    t_edge();
    t_decoded();
    t_reset();
    stop_test();
  end
endmodule
